// ### rtl/isa_bus_self_status_regs.sv
// How it works
// - self status read returns pattern 010110 in bits 5..0.
// - init-done flag set only once initialisation and nvm readout finish.
// - serial busy flag mirrors the nvm chip-select output exactly.
// - nvm-present flag captured from nvm data pin right after reset.
// - checksum-good flag set when nvm readout checksum is correct.
// - external-decoder flag set when external address latch logic is detected.
// - size flag valid only with present and good; set means 64 words.
// - rx dma reset ends dma, clears rx buffers, zeroes offset pointer.
// - with extend, request drops on falling edge of the final read strobe.
// - demand mode by default; extend selects single-transfer mode.
// - use-system-address gates memcs16 on address match, else chip select alone.
// - memcs16 enabled only in memory mode with memory enable set.
// - memory enable permits memory-mode access; io mode always available.
// - burst limit caps a dma access at 28us, then 1.3us release.
// - ready disable set: ready pin never driven, left floating.
// - ready pin only extends io reads and memory reads, never dma.
// - ring size control picks 64K or 16K host ring.
// - interrupt enable gates every interrupt; clear means none.
// - bus status read returns pattern 011000 in bits 5..0.
// - bid error on oversize frames: over 1514 with crc, over 1518 always.
// - ready-for-transmit-now is pollable and raises no interrupt.
// - crc inhibit suppresses crc append and relaxes the bid limit.
`timescale 1ns/100ps
`default_nettype none

module isa_bus_self_status_regs
    import isa_status_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // chip status inputs
    input wire logic init_complete,
    input wire logic low_supply_flag,
    input wire logic nvm_chip_select_out,
    input wire logic nvm_data_in_pin,
    input wire logic nvm_checksum_ok,
    input wire logic ext_decoder_detected,
    input wire logic nvm_is_64_words,
    // transmit bid
    input wire logic tx_bid_strobe,
    input wire logic [15:0] tx_bid_length,
    input wire logic crc_append_inhibit,
    input wire logic ready_for_transmit_now,
    // receive dma
    input wire logic rx_frame_pending,
    input wire logic [11:0] rx_words_left,
    input wire logic ior_n,
    input wire logic memr_n,
    input wire logic dma_acknowledge_in,
    output logic dma_request_out,
    output logic rx_dma_reset_pulse,
    output logic [15:0] rx_dma_offset,
    output logic rx_dma_ring64,
    output logic crc_append_enable,
    // memory decode
    input wire logic memory_mode,
    input wire logic chip_select_pin,
    input wire logic [7:0] sa_high,
    input wire logic [7:0] mem_base,
    output logic memory_access_ok,
    output logic memcs16_o,
    output logic memcs16_oe,
    // ready extension
    input wire logic slow_read,
    output logic iochrdy_o,
    output logic iochrdy_oe,
    // interrupt
    input wire logic irq_event,
    output logic irq_out
);

    // ============================================================
    // register state
    // ============================================================
    regs_s r, next_r;
    logic wr_ctl, rd_any, bid_bad, size_valid, nvm_checksum_good_q;
    logic [15:0] self_word, ctl_word, bst_word, ring_mask;

    assign wr_ctl = reg_wr && (reg_addr == `BUS_CONTROL_ADDR);
    assign rd_any = reg_rd;
    assign nvm_checksum_good_q = init_complete && nvm_checksum_ok;
    assign size_valid = r.present && nvm_checksum_good_q;

    // crc inhibit lets the frame carry four more bytes
    always_comb begin
        if (crc_append_inhibit) begin
            bid_bad = tx_bid_length > `BID_LIMIT_ANY;
        end else begin
            bid_bad = tx_bid_length > `BID_LIMIT_CRC;
        end
    end

    assign ring_mask = r.ring64 ? `RING64_MASK : `RING16_MASK;

    // ============================================================
    // read words
    // ============================================================
    always_comb begin
        self_word = '0;
        self_word[5:0] = `SELF_STATUS_ID;
        self_word[`SS_LOW_SUPPLY] = low_supply_flag;
        self_word[`SS_INIT_DONE] = init_complete;
        self_word[`SS_SI_BUSY] = nvm_chip_select_out;
        self_word[`SS_NVM_PRESENT] = r.present;
        self_word[`SS_NVM_GOOD] = nvm_checksum_good_q;
        self_word[`SS_EXT_DEC] = ext_decoder_detected;
        // size is forced clear when it would not mean anything
        self_word[`SS_NVM_SIZE] = size_valid && nvm_is_64_words;
    end

    always_comb begin
        ctl_word = '0;
        ctl_word[5:0] = `BUS_CONTROL_ID;
        ctl_word[`BC_DMA_EXTEND] = r.dma_extend;
        ctl_word[`BC_USE_SA] = r.use_sa;
        ctl_word[`BC_MEM_EN] = r.mem_en;
        ctl_word[`BC_BURST] = r.burst;
        ctl_word[`BC_RDY_DIS] = r.rdy_dis;
        ctl_word[`BC_RING64] = r.ring64;
        ctl_word[`BC_IRQ_EN] = r.irq_en;
    end

    always_comb begin
        bst_word = '0;
        bst_word[5:0] = `BUS_STATUS_ID;
        bst_word[`BS_BID_ERR] = r.bid_err;
        bst_word[`BS_RDY_NOW] = ready_for_transmit_now;
    end

    // ============================================================
    // next state
    // ============================================================
    always_comb begin
        next_r = r;
        next_r.rx_reset = 1'b0;
        next_r.ior_prev = ior_n;
        // strap catch: first enabled cycle after reset release
        if (!r.sampled) begin
            next_r.sampled = 1'b1;
            next_r.present = nvm_data_in_pin;
        end
        if (rd_any) begin
            case (reg_addr)
                `CHIP_SELF_STATUS_ADDR: next_r.rdata = self_word;
                `BUS_CONTROL_ADDR: next_r.rdata = ctl_word;
                `BUS_STATUS_ADDR: next_r.rdata = bst_word;
                `RX_DMA_OFFSET_ADDR: next_r.rdata = r.offset;
                default: next_r.rdata = '0;
            endcase
        end
        if (wr_ctl) begin
            next_r.dma_extend = reg_wdata[`BC_DMA_EXTEND];
            next_r.use_sa = reg_wdata[`BC_USE_SA];
            next_r.mem_en = reg_wdata[`BC_MEM_EN];
            next_r.burst = reg_wdata[`BC_BURST];
            next_r.rdy_dis = reg_wdata[`BC_RDY_DIS];
            next_r.ring64 = reg_wdata[`BC_RING64];
            next_r.irq_en = reg_wdata[`BC_IRQ_EN];
            // act-once: never stored, reads back zero
            next_r.rx_reset = reg_wdata[`BC_RX_DMA_RESET];
        end
        // a legal bid clears the error, an oversize one sets it
        if (tx_bid_strobe) begin
            next_r.bid_err = bid_bad;
        end
        // each completed dma read advances the pointer by one word inside the ring
        if (!r.ior_prev && ior_n && dma_acknowledge_in) begin
            next_r.offset = (r.offset + `DMA_WORD_BYTES) & ring_mask;
        end
        if (r.rx_reset) begin
            next_r.offset = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.ior_prev <= 1'b1;
        end else if (ce) begin
            r <= next_r;
        end
    end

    // ============================================================
    // outputs
    // ============================================================
    assign reg_rdata = r.rdata;
    assign rx_dma_reset_pulse = r.rx_reset;
    assign rx_dma_offset = r.offset;
    assign rx_dma_ring64 = r.ring64;
    assign crc_append_enable = !crc_append_inhibit;

    dma_pacer u_pacer (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .frame_pending(rx_frame_pending),
        .abort(r.rx_reset),
        .dma_extend(r.dma_extend),
        .burst_limit(r.burst),
        .ior_n(ior_n),
        .dma_acknowledge_in(dma_acknowledge_in),
        .words_left(rx_words_left),
        .dma_request_out(dma_request_out)
    );

    assign memory_access_ok = memory_mode && r.mem_en;
    assign memcs16_oe = memory_access_ok;
    // pin level low means asserted; internal decode needs the base match too
    assign memcs16_o = r.use_sa ? !((sa_high == mem_base) && !chip_select_pin)
                                : chip_select_pin;

    // dma reads are never stretched since the controller cannot honour it
    assign iochrdy_o = 1'b0;
    assign iochrdy_oe = !r.rdy_dis && slow_read && !dma_acknowledge_in &&
                        (!ior_n || (!memr_n && memory_access_ok));

    assign irq_out = r.irq_en && irq_event;

    // ============================================================
    // checks
    // ============================================================
    property p_self_id;
        @(posedge clk) disable iff (!rst_n)
        (ce && reg_rd && reg_addr == `CHIP_SELF_STATUS_ADDR) |=> (reg_rdata[5:0] == `SELF_STATUS_ID);
    endproperty
    a_self_id: assert property (p_self_id) else $error("self status id wrong");

    property p_bst_id;
        @(posedge clk) disable iff (!rst_n)
        (ce && reg_rd && reg_addr == `BUS_STATUS_ADDR) |=> (reg_rdata[15:9] == 7'h00 &&
                                                            reg_rdata[5:0] == `BUS_STATUS_ID);
    endproperty
    a_bst_id: assert property (p_bst_id) else $error("bus status id or spare bits wrong");

    property p_busy;
        @(posedge clk) disable iff (!rst_n)
        (ce && reg_rd && reg_addr == `CHIP_SELF_STATUS_ADDR) |=>
            (reg_rdata[`SS_SI_BUSY] == $past(nvm_chip_select_out));
    endproperty
    a_busy: assert property (p_busy) else $error("busy flag does not follow chip select");

    property p_offset_zero;
        @(posedge clk) disable iff (!rst_n)
        (ce && wr_ctl && reg_wdata[`BC_RX_DMA_RESET]) ##1 ce |=> (rx_dma_offset == 16'h0000);
    endproperty
    a_offset_zero: assert property (p_offset_zero) else $error("rx reset did not zero pointer");

    property p_bid;
        @(posedge clk) disable iff (!rst_n)
        (ce && tx_bid_strobe && !crc_append_inhibit && tx_bid_length > `BID_LIMIT_CRC) |=> r.bid_err;
    endproperty
    a_bid: assert property (p_bid) else $error("oversize bid not flagged");

    property p_rdy_float;
        @(posedge clk) disable iff (!rst_n)
        r.rdy_dis |-> !iochrdy_oe;
    endproperty
    a_rdy_float: assert property (p_rdy_float) else $error("ready driven while disabled");

    property p_memcs_en;
        @(posedge clk) disable iff (!rst_n)
        memcs16_oe |-> (memory_mode && r.mem_en);
    endproperty
    a_memcs_en: assert property (p_memcs_en) else $error("memcs16 enabled outside memory mode");

    property p_irq_gate;
        @(posedge clk) disable iff (!rst_n)
        (!r.irq_en) |-> !irq_out;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt while disabled");

    property p_size;
        @(posedge clk) disable iff (!rst_n)
        (ce && reg_rd && reg_addr == `CHIP_SELF_STATUS_ADDR && !r.present) |=> !reg_rdata[`SS_NVM_SIZE];
    endproperty
    a_size: assert property (p_size) else $error("size flag shown without nvm");

    property p_ctl_id;
        @(posedge clk) disable iff (!rst_n)
        (ce && reg_rd && reg_addr == `BUS_CONTROL_ADDR) |=> (reg_rdata[6:0] == {1'b0, `BUS_CONTROL_ID});
    endproperty
    a_ctl_id: assert property (p_ctl_id) else $error("bus control id wrong");

    property p_req_abort;
        @(posedge clk) disable iff (!rst_n)
        (ce && r.rx_reset) |=> !dma_request_out;
    endproperty
    a_req_abort: assert property (p_req_abort) else $error("request kept after rx reset");

    property p_rdy_dma;
        @(posedge clk) disable iff (!rst_n)
        dma_acknowledge_in |-> !iochrdy_oe;
    endproperty
    a_rdy_dma: assert property (p_rdy_dma) else $error("dma read stretched");

    property p_irq_pass;
        @(posedge clk) disable iff (!rst_n)
        r.irq_en |-> (irq_out == irq_event);
    endproperty
    a_irq_pass: assert property (p_irq_pass) else $error("enabled interrupt lost");

    property p_bid_ok;
        @(posedge clk) disable iff (!rst_n)
        (ce && tx_bid_strobe && tx_bid_length <= `BID_LIMIT_CRC) |=> !r.bid_err;
    endproperty
    a_bid_ok: assert property (p_bid_ok) else $error("legal bid flagged");

    property p_bid_any;
        @(posedge clk) disable iff (!rst_n)
        (ce && tx_bid_strobe && tx_bid_length > `BID_LIMIT_ANY) |=> r.bid_err;
    endproperty
    a_bid_any: assert property (p_bid_any) else $error("bid over any limit not flagged");

    property p_memcs_sa;
        @(posedge clk) disable iff (!rst_n)
        (r.use_sa && !memcs16_o) |-> (sa_high == mem_base && !chip_select_pin);
    endproperty
    a_memcs_sa: assert property (p_memcs_sa) else $error("memcs16 without address match");

    property p_memcs_cs;
        @(posedge clk) disable iff (!rst_n)
        !r.use_sa |-> (memcs16_o == chip_select_pin);
    endproperty
    a_memcs_cs: assert property (p_memcs_cs) else $error("memcs16 not following chip select");

    property p_rdy_now;
        @(posedge clk) disable iff (!rst_n)
        (ce && reg_rd && reg_addr == `BUS_STATUS_ADDR) |=>
            (reg_rdata[`BS_RDY_NOW] == $past(ready_for_transmit_now));
    endproperty
    a_rdy_now: assert property (p_rdy_now) else $error("ready now flag wrong");

    property p_present_keep;
        @(posedge clk) disable iff (!rst_n)
        r.sampled |=> $stable(r.present);
    endproperty
    a_present_keep: assert property (p_present_keep) else $error("nvm present flag moved");

endmodule

`default_nettype wire

// ### include/isa_status_defines.svh
`ifndef ISA_STATUS_DEFINES_SVH
`define ISA_STATUS_DEFINES_SVH

// register byte offsets in register space
`define BUS_CONTROL_ADDR 16'h0116
`define CHIP_SELF_STATUS_ADDR 16'h0136
`define BUS_STATUS_ADDR 16'h0138
`define RX_DMA_OFFSET_ADDR 16'h0026

// fixed identifier patterns in bits 5..0
`define SELF_STATUS_ID 6'h16
`define BUS_CONTROL_ID 6'h17
`define BUS_STATUS_ID 6'h18
`define BUS_CONTROL_RESET 16'h0017

// chip_self_status fields
`define SS_LOW_SUPPLY 6
`define SS_INIT_DONE 7
`define SS_SI_BUSY 8
`define SS_NVM_PRESENT 9
`define SS_NVM_GOOD 10
`define SS_EXT_DEC 11
`define SS_NVM_SIZE 12

// bus_control fields
`define BC_RX_DMA_RESET 6
`define BC_DMA_EXTEND 8
`define BC_USE_SA 9
`define BC_MEM_EN 10
`define BC_BURST 11
`define BC_RDY_DIS 12
`define BC_RING64 13
`define BC_IRQ_EN 15

// bus_status fields
`define BS_BID_ERR 7
`define BS_RDY_NOW 8

// transmit bid limits in bytes
`define BID_LIMIT_CRC 16'd1514
`define BID_LIMIT_ANY 16'd1518

// ring masks for the receive offset pointer
`define RING16_MASK 16'h3fff
`define RING64_MASK 16'hffff
`define DMA_WORD_BYTES 16'h0002

// dma pacing times and clock period in ns
`define CLK_PERIOD_NS 8
`define BURST_MAX_NS 28000
`define BUS_GAP_NS 1300
`define BURST_CYC ((`BURST_MAX_NS) / (`CLK_PERIOD_NS))
`define GAP_CYC (((`BUS_GAP_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define PACE_W 12
`define WORDS_W 12

`endif

// ### include/isa_status_pkg.sv
`include "isa_status_defines.svh"

package isa_status_pkg;

    typedef enum logic [1:0] {
        PACE_IDLE,
        PACE_REQ,
        PACE_GAP
    } pace_state_e;

    typedef struct packed {
        pace_state_e state;
        logic [`PACE_W-1:0] cnt;
        logic ior_prev;
    } pace_s;

    typedef struct packed {
        logic [15:0] rdata;
        logic dma_extend;
        logic use_sa;
        logic mem_en;
        logic burst;
        logic rdy_dis;
        logic ring64;
        logic irq_en;
        logic sampled;
        logic present;
        logic bid_err;
        logic [15:0] offset;
        logic rx_reset;
        logic ior_prev;
    } regs_s;

endpackage

// ### rtl/dma_pacer.sv
`timescale 1ns/100ps
`default_nettype none

module dma_pacer
    import isa_status_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic frame_pending,
    input wire logic abort,
    input wire logic dma_extend,
    input wire logic burst_limit,
    input wire logic ior_n,
    input wire logic dma_acknowledge_in,
    input wire logic [`WORDS_W-1:0] words_left,
    output logic dma_request_out
);

    pace_s r, next_r;
    logic rd_fall, rd_rise, last_read;

    assign rd_fall = r.ior_prev && !ior_n && dma_acknowledge_in;
    assign rd_rise = !r.ior_prev && ior_n && dma_acknowledge_in;

    // extended mode drops on the final strobe's falling edge, else on the previous rising edge
    always_comb begin
        if (dma_extend) begin
            last_read = rd_fall && (words_left == `WORDS_W'(1));
        end else begin
            last_read = (rd_rise && (words_left == `WORDS_W'(2))) ||
                        (rd_fall && (words_left == `WORDS_W'(1)));
        end
    end

    always_comb begin
        next_r = r;
        next_r.ior_prev = ior_n;
        case (r.state)
            PACE_IDLE: begin
                next_r.cnt = '0;
                if (frame_pending && !abort) begin
                    next_r.state = PACE_REQ;
                end
            end
            PACE_REQ: begin
                // only limited bursts are timed, so an unlimited one never trips the cap
                if (burst_limit) begin
                    next_r.cnt = r.cnt + `PACE_W'(1);
                end
                if (abort || last_read) begin
                    next_r.state = PACE_IDLE;
                end else if (burst_limit && r.cnt == `PACE_W'(`BURST_CYC - 1)) begin
                    next_r.state = PACE_GAP;
                    next_r.cnt = '0;
                end
            end
            PACE_GAP: begin
                next_r.cnt = r.cnt + `PACE_W'(1);
                if (r.cnt == `PACE_W'(`GAP_CYC - 1)) begin
                    next_r.state = PACE_IDLE;
                end
            end
            default: begin
                next_r.state = PACE_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{state: PACE_IDLE, cnt: '0, ior_prev: 1'b1};
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign dma_request_out = (r.state == PACE_REQ);

    property p_burst_cap;
        @(posedge clk) disable iff (!rst_n)
        (r.state == PACE_REQ) |-> (r.cnt < `PACE_W'(`BURST_CYC));
    endproperty
    a_burst_cap: assert property (p_burst_cap) else $error("dma burst ran past limit");

    property p_gap_hold;
        @(posedge clk) disable iff (!rst_n)
        ($rose(r.state == PACE_GAP) && ce) |-> !dma_request_out [*8];
    endproperty
    a_gap_hold: assert property (p_gap_hold) else $error("request during release gap");

endmodule

`default_nettype wire

// ### bench/isa_host_dma_model.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// host dma controller: one read per 8 cycles
module isa_host_dma_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic dma_request_out,
    input wire logic single_mode,
    input wire logic slow,
    output logic ior_n,
    output logic dma_acknowledge_in
);
    logic [2:0] ph;
    logic more;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph <= 3'h0;
            more <= 1'b0;
            ior_n <= 1'b1;
            dma_acknowledge_in <= 1'b0;
        end else if (!dma_acknowledge_in) begin
            // slow grant waits for the phase counter to wrap
            if (dma_request_out && (!slow || ph == 3'h7)) begin
                dma_acknowledge_in <= 1'b1;
                ph <= 3'h0;
            end else begin
                ph <= ph + 3'h1;
            end
        end else begin
            ph <= ph + 3'h1;
            if (ph == 3'h1) begin
                ior_n <= 1'b0;
            end
            if (ph == 3'h4) begin
                ior_n <= 1'b1;
                more <= dma_request_out;
            end
            // demand mode keeps the grant until the request has gone
            if (ph == 3'h6 && (!more || single_mode)) begin
                dma_acknowledge_in <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// ### bench/isa_bus_self_status_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none

module isa_bus_self_status_regs_tb
    import isa_status_pkg::*;
;
    logic clk, rst_n, ce, reg_wr, reg_rd, init_complete, low_supply_flag, nvm_chip_select_out, nvm_data_in_pin;
    logic nvm_checksum_ok, ext_decoder_detected, nvm_is_64_words, tx_bid_strobe, crc_append_inhibit;
    logic ready_for_transmit_now, rx_frame_pending, memr_n, memory_mode, chip_select_pin, slow_read, irq_event;
    logic single_mode, slow, ior_n, dma_acknowledge_in, dma_request_out, rx_dma_reset_pulse, rx_dma_ring64;
    logic crc_append_enable, memory_access_ok, memcs16_o, memcs16_oe, iochrdy_o, iochrdy_oe, irq_out;
    logic rd_seen, ior_prev, frame_go;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, tx_bid_length, rx_dma_offset;
    logic [11:0] rx_words_left, frame_len;
    logic [7:0] sa_high, mem_base;
    logic [15:0] lens [5] = '{16'd60, 16'd1514, 16'd1515, 16'd1518, 16'd1519};
    logic [15:0] expq [$];
    int mismatches, n_compared, seed, pulses;

    isa_bus_self_status_regs isa_bus_self_status_regs_inst (.clk, .rst_n, .ce, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .init_complete, .low_supply_flag, .nvm_chip_select_out, .nvm_data_in_pin,
        .nvm_checksum_ok, .ext_decoder_detected, .nvm_is_64_words, .tx_bid_strobe, .tx_bid_length,
        .crc_append_inhibit, .ready_for_transmit_now, .rx_frame_pending, .rx_words_left, .ior_n, .memr_n,
        .dma_acknowledge_in, .dma_request_out, .rx_dma_reset_pulse, .rx_dma_offset, .rx_dma_ring64,
        .crc_append_enable, .memory_mode, .chip_select_pin, .sa_high, .mem_base, .memory_access_ok,
        .memcs16_o, .memcs16_oe, .slow_read, .iochrdy_o, .iochrdy_oe, .irq_event, .irq_out);

    isa_host_dma_model isa_host_dma_model_inst (.clk, .rst_n, .dma_request_out, .single_mode, .slow, .ior_n,
        .dma_acknowledge_in);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ==========================================
    // checking
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        cmp16({15'h0, got}, {15'h0, exp});
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // read data lands one cycle after the read edge
    always @(posedge clk) begin
        if (rd_seen && expq.size() > 0) begin
            cmp16(reg_rdata, expq.pop_front());
        end
        rd_seen <= reg_rd & rst_n;
        if (rx_dma_reset_pulse === 1'b1) begin
            pulses++;
        end
        if (dma_acknowledge_in === 1'b1) begin
            cmp1(iochrdy_oe, 1'b0);
        end
        // the dma side counts words down as each read completes
        if (!rst_n) begin
            rx_words_left <= 12'h0;
            rx_frame_pending <= 1'b0;
        end else if (frame_go) begin
            rx_words_left <= frame_len;
            rx_frame_pending <= 1'b1;
        end else if (ior_n && !ior_prev && dma_acknowledge_in) begin
            rx_words_left <= rx_words_left - 12'h1;
            if (rx_words_left == 12'h2) begin
                rx_frame_pending <= 1'b0;
            end
        end
        ior_prev <= ior_n;
    end

    // ==========================================
    // register port
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        expq.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic do_reset(input logic pin);
        nvm_data_in_pin <= pin;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    function automatic logic [15:0] self_exp(input logic present);
        logic good;
        good = init_complete & nvm_checksum_ok;
        return {3'h0, present & good & nvm_is_64_words, ext_decoder_detected, good, present,
                nvm_chip_select_out, init_complete, low_supply_flag, 6'h16};
    endfunction

    // ==========================================
    // main sequence
    initial begin
        logic [31:0] r;
        logic [15:0] w;
        logic bid;
        int k;
        int j;
        int n;
        {rst_n, reg_wr, reg_rd, init_complete, low_supply_flag, nvm_chip_select_out, nvm_data_in_pin} = '0;
        {nvm_checksum_ok, ext_decoder_detected, nvm_is_64_words, tx_bid_strobe, crc_append_inhibit} = '0;
        {ready_for_transmit_now, frame_go, memory_mode, slow_read, irq_event, single_mode, slow} = '0;
        {reg_addr, reg_wdata, tx_bid_length, frame_len, sa_high, mem_base} = '0;
        {ce, memr_n, chip_select_pin} = 3'h7;
        seed = 12465;
        do_reset(1'b1);
        rd(16'h0136, self_exp(1'b1));
        rd(16'h0116, 16'h0017);
        rd(16'h0138, 16'h0018);
        rd(16'h0130, 16'h0000);
        for (k = 0; k < 10; k++) begin
            tx_bid_length <= lens[k / 2];
            crc_append_inhibit <= k[0];
            tx_bid_strobe <= 1'b1;
            @(posedge clk);
            tx_bid_strobe <= 1'b0;
            @(posedge clk);
            bid = lens[k / 2] > 16'd1518 || (lens[k / 2] > 16'd1514 && !k[0]);
            cmp1(crc_append_enable, !k[0]);
            rd(16'h0138, {7'h0, ready_for_transmit_now, bid, 7'h18});
        end
        for (k = 0; k < 24; k++) begin
            r = $random(seed);
            {init_complete, low_supply_flag, nvm_chip_select_out, nvm_checksum_ok} <= r[3:0];
            {ext_decoder_detected, nvm_is_64_words, ready_for_transmit_now, irq_event} <= r[7:4];
            {memory_mode, chip_select_pin, slow_read, memr_n} <= r[11:8];
            mem_base <= r[19:12];
            sa_high <= r[20] ? r[19:12] : r[31:24];
            r = $random(seed);
            w = r[15:0] & 16'hffbf;
            wr(16'h0116, w);
            rd(16'h0136, self_exp(1'b1));
            rd(16'h0116, (w & 16'hbf00) | 16'h0017);
            cmp1(irq_out, w[15] & irq_event);
            cmp1(rx_dma_ring64, w[13]);
            cmp1(memcs16_oe, memory_mode & w[10]);
            if (memory_mode && w[10]) begin
                cmp1(memcs16_o, w[9] ? !(sa_high == mem_base && !chip_select_pin) : chip_select_pin);
            end
            if (memory_mode) begin
                cmp1(memory_access_ok, w[10]);
            end
            cmp1(iochrdy_oe, !w[12] && !memr_n && slow_read && memory_mode && w[10]);
            if (iochrdy_oe === 1'b1) begin
                cmp1(iochrdy_o, 1'b0);
            end
        end
        // dma in demand mode, single-transfer mode with a prompt host, then a long burst-limited frame
        memr_n <= 1'b1;
        slow_read <= 1'b1;
        for (k = 0; k < 3; k++) begin
            n = k[1] ? 500 : 2 + k * 3;
            single_mode <= k[0];
            slow <= !k[0];
            wr(16'h0116, {4'h0, k[1], 2'h0, k[0], 8'h40});
            frame_len <= 12'(n);
            frame_go <= 1'b1;
            @(posedge clk);
            frame_go <= 1'b0;
            @(posedge clk);
            cmp16(16'(pulses), 16'(k + 1));
            cmp16(rx_dma_offset, 16'h0000);
            for (j = 0; j < 6000 && !(rx_words_left === 12'h0 && dma_acknowledge_in === 1'b0); j++) begin
                @(posedge clk);
            end
            if (j == 6000) begin
                mismatches++;
                report_and_stop();
            end
            repeat (4) @(posedge clk);
            cmp1(dma_request_out, 1'b0);
            cmp16(rx_dma_offset, 16'(2 * n));
            rd(16'h0026, 16'(2 * n));
        end
        // the host never touches the nvm command or data words here
        do_reset(1'b0);
        cmp16(rx_dma_offset, 16'h0000);
        rd(16'h0136, self_exp(1'b0));
        rd(16'h0116, 16'h0017);
        rd(16'h0138, {7'h0, ready_for_transmit_now, 8'h18});
        repeat (2) @(posedge clk);
        report_and_stop();
    end
endmodule

`default_nettype wire
